// *** common/fracn_pkg.sv ***
package fracn_pkg;

  // Register word, as delivered by the serial port
  localparam int ADDR_W = 5;
  localparam int DATA_W = 24;

  // Register offsets
  localparam logic [4:0] REF_DIV_ADDR = 5'h02;
  localparam logic [4:0] INT_ADDR = 5'h03;
  localparam logic [4:0] FRAC_ADDR = 5'h04;
  localparam logic [4:0] OSC_PORT_ADDR = 5'h05;
  localparam logic [4:0] MOD_CFG_ADDR = 5'h06;
  localparam logic [4:0] PRESCALE_ADDR = 5'h08;
  localparam logic [4:0] EXACT_ADDR = 5'h0c;
  localparam logic [4:0] STATUS_ADDR = 5'h10;

  // Field widths
  localparam int INT_W = 19;
  localparam int FRAC_W = 24;
  localparam int STEP_W = 14;
  localparam int CNT_W = INT_W + 1;

  // Modulator configuration fields
  localparam int MOD_FRAC_EN_BIT = 11;
  localparam int MOD_BYPASS_BIT = 7;
  localparam int SEED_LSB = 0;
  localparam int SEED_W = 2;

  // Prescaler select
  localparam int PRESCALE_BIT = 19;

  // Indirect oscillator port word layout
  localparam int OSC_DATA_LSB = 0;
  localparam int OSC_DATA_W = 9;
  localparam int OSC_ADDR_LSB = 9;
  localparam int OSC_ADDR_W = 4;
  localparam logic [3:0] OSC_ENABLE_REG = 4'h1;
  localparam int OSC_ENABLE_BIT = 8;
  localparam logic [3:0] OSC_DIV_REG = 4'h2;
  localparam int OSC_DIV_LSB = 0;
  localparam int OSC_DIV_W = 3;
  localparam int RATIO_W = 8;

  // Status word fields
  localparam int STAT_INT_MODE_BIT = 19;
  localparam int STAT_PENDING_BIT = 20;

  // Limits
  localparam logic [CNT_W-1:0] INT_MIN = 20'h00010;

  // Reset values
  localparam logic [23:0] REF_DIV_RESET = 24'h000001;
  localparam logic [INT_W-1:0] INT_RESET = 19'h00010;
  localparam logic [FRAC_W-1:0] FRAC_RESET = 24'h000000;
  localparam logic [SEED_W-1:0] SEED_RESET = 2'h2;
  localparam logic [STEP_W-1:0] STEP_RESET = 14'h0000;

  // Start seeds for the phase accumulator
  localparam logic [FRAC_W-1:0] SEED_ZERO = 24'h000000;
  localparam logic [FRAC_W-1:0] SEED_QUARTER = 24'h400000;
  localparam logic [FRAC_W-1:0] SEED_RANDOM = 24'hb7a3c5;
  localparam logic [FRAC_W-1:0] SEED_HALF = 24'h800000;

  function automatic logic [FRAC_W-1:0] seed_value(
      input logic [SEED_W-1:0] sel);
    case (sel)
      2'h0: seed_value = SEED_ZERO;
      2'h1: seed_value = SEED_QUARTER;
      2'h2: seed_value = SEED_RANDOM;
      default: seed_value = SEED_HALF;
    endcase
  endfunction

endpackage

// *** core/fractional_n_divider_control.sv ***
// Summary of operation
// - Integer mode: modulator off, divide 16..2^19-1
// - Oscillator registers reached only through forwarding
// - Output divide ratio 1, or a power of two from 2 to 128
// - Fraction equals register over 2^24
// - Reference divided by ratio gives comparison rate
// - Integer field 19 bits, fraction 24 bits
// - Main output doubled; divided output uses ratio
// - Fixed 2^24 modulus sets resolution
// - Exact mode keeps full 24-bit accumulator
// - Seed reloaded on each new fractional frequency
`timescale 1ns/1ps
`default_nettype none
module fractional_n_divider_control #(
  parameter int REF_DIV_W = 14
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Completed serial register write
  input wire logic wr_en,
  input wire logic [fracn_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [fracn_pkg::DATA_W-1:0] wr_data,
  // Register readback
  input wire logic [fracn_pkg::ADDR_W-1:0] rd_addr,
  output logic [fracn_pkg::DATA_W-1:0] rd_data,
  // Edges of reference and oscillator, one clock each
  input wire logic ref_edge,
  input wire logic vco_edge,
  // Divider outputs
  output logic comparison_rate,
  output logic feedback_tick,
  output logic [fracn_pkg::CNT_W-1:0] active_ratio,
  output logic integer_mode,
  output logic prescaler_div2,
  // Oscillator subsystem forwarding
  output logic osc_wr_valid,
  output logic [fracn_pkg::OSC_ADDR_W-1:0] osc_wr_addr,
  output logic [fracn_pkg::OSC_DATA_W-1:0] osc_wr_data,
  output logic [fracn_pkg::RATIO_W-1:0] out_div_ratio,
  output logic out_div_enable
);

  localparam int INT_W = fracn_pkg::INT_W;
  localparam int FRAC_W = fracn_pkg::FRAC_W;
  localparam int STEP_W = fracn_pkg::STEP_W;
  localparam int CNT_W = fracn_pkg::CNT_W;
  localparam int DATA_W = fracn_pkg::DATA_W;
  localparam int OAW = fracn_pkg::OSC_ADDR_W;
  localparam int ODW = fracn_pkg::OSC_DATA_W;
  localparam int RW = fracn_pkg::RATIO_W;

  if (REF_DIV_W < 1 || REF_DIV_W > DATA_W) begin : g_bad_ref_w
    $error("REF_DIV_W must lie between 1 and the register width");
  end

  if (STEP_W > DATA_W || INT_W + 2 > DATA_W) begin : g_bad_fields
    $error("Register fields must fit the register word");
  end

  typedef struct packed {
    logic [REF_DIV_W-1:0] ref_div;
    logic [INT_W-1:0] int_div;
    logic [FRAC_W-1:0] frac;
    logic frac_en;
    logic bypass;
    logic [fracn_pkg::SEED_W-1:0] seed_sel;
    logic prescale;
    logic [STEP_W-1:0] steps;
    logic [fracn_pkg::OSC_DIV_W-1:0] osc_div_sel;
    logic osc_div_en;
    logic pending;
    logic [INT_W-1:0] act_int;
    logic act_int_mode;
    logic [CNT_W-1:0] act_ratio;
    logic load;
    logic [REF_DIV_W-1:0] ref_cnt;
    logic [CNT_W-1:0] fb_cnt;
    logic pre_phase;
    logic pd_tick;
    logic fb_tick;
    logic osc_valid;
    logic [OAW-1:0] osc_addr;
    logic [ODW-1:0] osc_data;
    logic [RW-1:0] ratio;
    logic [DATA_W-1:0] rd_data;
  } state_type;

  state_type q;
  state_type d;

  logic carry_up;
  logic carry_down;
  logic [FRAC_W-1:0] mod_acc;

  // Effective divide ratio; integer mode ignores the modulator
  function automatic logic [CNT_W-1:0] eff_ratio(
      input logic [INT_W-1:0] n, input logic int_mode,
      input logic up, input logic down);
    logic [CNT_W-1:0] base;
    base = {1'b0, n};
    if (base < fracn_pkg::INT_MIN) begin
      base = fracn_pkg::INT_MIN;
    end
    if (int_mode) begin
      eff_ratio = base;
    end else begin
      eff_ratio = base + {{(CNT_W-1){1'b0}}, up}
                  - {{(CNT_W-1){1'b0}}, down};
    end
  endfunction

  always_comb begin
    logic cnt_edge;
    logic apply;
    logic [CNT_W-1:0] next_ratio;
    logic [OAW-1:0] oa;
    logic [ODW-1:0] od;
    logic int_sel;
    cnt_edge = 1'b0;
    apply = 1'b0;
    next_ratio = '0;
    // Integer mode unless the modulator is enabled and in circuit
    int_sel = ~q.frac_en | q.bypass;
    oa = wr_data[fracn_pkg::OSC_ADDR_LSB +: OAW];
    od = wr_data[fracn_pkg::OSC_DATA_LSB +: ODW];
    d = q;
    d.pd_tick = 1'b0;
    d.fb_tick = 1'b0;
    d.load = 1'b0;
    d.osc_valid = 1'b0;

    // Reference divider; a zero ratio behaves as one
    // Live ratio compared, so a rewrite acts at once
    if (ref_edge) begin
      if (q.ref_cnt + 1'b1 >= q.ref_div || q.ref_div == '0) begin
        d.ref_cnt = '0;
        d.pd_tick = 1'b1;
      end else begin
        d.ref_cnt = q.ref_cnt + 1'b1;
      end
    end

    // Prescaler halves the oscillator edges when selected
    if (vco_edge && q.prescale) begin
      d.pre_phase = ~q.pre_phase;
    end
    cnt_edge = vco_edge && (~q.prescale || q.pre_phase);

    // Feedback divider; pending settings swap in at a cycle boundary
    if (cnt_edge) begin
      if (q.fb_cnt == '0) begin
        d.fb_tick = 1'b1;
        apply = q.pending;
        if (apply) begin
          // No carry here: the modulator is being reloaded
          d.act_int = q.int_div;
          d.act_int_mode = int_sel;
          d.load = 1'b1;
          d.pending = 1'b0;
          next_ratio = eff_ratio(q.int_div, int_sel, 1'b0, 1'b0);
        end else begin
          next_ratio = eff_ratio(q.act_int, q.act_int_mode,
                                 carry_up, carry_down);
        end
        d.act_ratio = next_ratio;
        d.fb_cnt = next_ratio - 1'b1;
      end else begin
        d.fb_cnt = q.fb_cnt - 1'b1;
      end
    end

    // Register writes; a write racing an apply stays pending
    if (wr_en) begin
      case (wr_addr)
        fracn_pkg::REF_DIV_ADDR: begin
          d.ref_div = wr_data[REF_DIV_W-1:0];
        end
        fracn_pkg::INT_ADDR: begin
          d.int_div = wr_data[INT_W-1:0];
          d.pending = 1'b1;
        end
        fracn_pkg::FRAC_ADDR: begin
          d.frac = wr_data[FRAC_W-1:0];
          d.pending = 1'b1;
        end
        fracn_pkg::OSC_PORT_ADDR: begin
          // Forwarded; the host never reaches these directly
          d.osc_valid = 1'b1;
          d.osc_addr = oa;
          d.osc_data = od;
          if (oa == fracn_pkg::OSC_DIV_REG) begin
            d.osc_div_sel = od[fracn_pkg::OSC_DIV_LSB +:
                               fracn_pkg::OSC_DIV_W];
          end
          if (oa == fracn_pkg::OSC_ENABLE_REG) begin
            d.osc_div_en = od[fracn_pkg::OSC_ENABLE_BIT];
          end
        end
        fracn_pkg::MOD_CFG_ADDR: begin
          d.frac_en = wr_data[fracn_pkg::MOD_FRAC_EN_BIT];
          d.bypass = wr_data[fracn_pkg::MOD_BYPASS_BIT];
          d.seed_sel = wr_data[fracn_pkg::SEED_LSB +:
                               fracn_pkg::SEED_W];
          d.pending = 1'b1;
        end
        fracn_pkg::PRESCALE_ADDR: begin
          d.prescale = wr_data[fracn_pkg::PRESCALE_BIT];
        end
        fracn_pkg::EXACT_ADDR: begin
          d.steps = wr_data[STEP_W-1:0];
          d.pending = 1'b1;
        end
        default: ;
      endcase
    end

    // Ratio of the divided output relative to the doubled output
    d.ratio = RW'(1) << d.osc_div_sel;

    case (rd_addr)
      fracn_pkg::REF_DIV_ADDR: d.rd_data = DATA_W'(q.ref_div);
      fracn_pkg::INT_ADDR: d.rd_data = DATA_W'(q.int_div);
      fracn_pkg::FRAC_ADDR: d.rd_data = q.frac;
      fracn_pkg::MOD_CFG_ADDR: begin
        d.rd_data = '0;
        d.rd_data[fracn_pkg::MOD_FRAC_EN_BIT] = q.frac_en;
        d.rd_data[fracn_pkg::MOD_BYPASS_BIT] = q.bypass;
        d.rd_data[fracn_pkg::SEED_LSB +: fracn_pkg::SEED_W] =
            q.seed_sel;
      end
      fracn_pkg::PRESCALE_ADDR: begin
        d.rd_data = '0;
        d.rd_data[fracn_pkg::PRESCALE_BIT] = q.prescale;
      end
      fracn_pkg::EXACT_ADDR: d.rd_data = DATA_W'(q.steps);
      fracn_pkg::STATUS_ADDR: begin
        d.rd_data = DATA_W'(q.act_int);
        d.rd_data[fracn_pkg::STAT_INT_MODE_BIT] = q.act_int_mode;
        d.rd_data[fracn_pkg::STAT_PENDING_BIT] = q.pending;
      end
      default: d.rd_data = '0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // Register defaults; applied state starts in integer mode
      q <= '0;
      q.ref_div <= fracn_pkg::REF_DIV_RESET[REF_DIV_W-1:0];
      q.int_div <= fracn_pkg::INT_RESET;
      q.frac <= fracn_pkg::FRAC_RESET;
      q.bypass <= 1'b1;
      q.seed_sel <= fracn_pkg::SEED_RESET;
      q.steps <= fracn_pkg::STEP_RESET;
      q.act_int <= fracn_pkg::INT_RESET;
      q.act_int_mode <= 1'b1;
      q.act_ratio <= fracn_pkg::INT_MIN;
      q.ratio <= RW'(1);
    end else begin
      q <= d;
    end
  end

  // Modulator steps once per feedback cycle, only in fractional mode
  modulator_accumulator u_mod (
    .clock(clock),
    .rst(rst),
    .load(q.load),
    .step(q.fb_tick && !q.act_int_mode),
    .frac(q.frac),
    .seed(fracn_pkg::seed_value(q.seed_sel)),
    .steps(q.steps),
    .carry_up(carry_up),
    .carry_down(carry_down),
    .acc(mod_acc)
  );

  assign rd_data = q.rd_data;
  assign comparison_rate = q.pd_tick;
  assign feedback_tick = q.fb_tick;
  assign active_ratio = q.act_ratio;
  assign integer_mode = q.act_int_mode;
  assign prescaler_div2 = q.prescale;
  assign osc_wr_valid = q.osc_valid;
  assign osc_wr_addr = q.osc_addr;
  assign osc_wr_data = q.osc_data;
  assign out_div_ratio = q.ratio;
  assign out_div_enable = q.osc_div_en;

endmodule
`default_nettype wire

// *** core/modulator_accumulator.sv ***
`timescale 1ns/1ps
`default_nettype none
module modulator_accumulator (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic step,
  input wire logic [fracn_pkg::FRAC_W-1:0] frac,
  input wire logic [fracn_pkg::FRAC_W-1:0] seed,
  input wire logic [fracn_pkg::STEP_W-1:0] steps,
  // Divider adjust for the next feedback cycle
  output logic carry_up,
  output logic carry_down,
  output logic [fracn_pkg::FRAC_W-1:0] acc
);

  localparam int W = fracn_pkg::FRAC_W;
  localparam int SW = fracn_pkg::STEP_W;

  typedef struct packed {
    logic [W-1:0] acc;
    logic [W-1:0] frac;
    logic [SW-1:0] steps;
    logic [W-1:0] corr;
    logic [SW-1:0] phase;
    logic up;
    logic down;
  } state_type;

  state_type q;
  state_type d;

  always_comb begin
    logic [W+SW-1:0] prod;
    logic [W+1:0] sum;
    logic wrap;
    prod = '0;
    sum = '0;
    wrap = 1'b0;
    d = q;
    if (load) begin
      // Fresh frequency: seed reloaded, error term precomputed
      prod = {{SW{1'b0}}, frac} * {{W{1'b0}}, steps};
      d.acc = seed;
      d.frac = frac;
      d.steps = steps;
      // Ceil rounding leaves frac*steps - k*2^24 over one period
      d.corr = prod[W-1:0];
      d.phase = '0;
      d.up = 1'b0;
      d.down = 1'b0;
    end else if (step) begin
      wrap = (q.steps != '0) && (q.phase == q.steps - 1'b1);
      // Full 24-bit modulus kept in exact mode too
      sum = {2'b00, q.acc} + {2'b00, q.frac};
      if (wrap) begin
        sum = sum - {2'b00, q.corr};
        d.phase = '0;
      end else if (q.steps != '0) begin
        d.phase = q.phase + 1'b1;
      end
      d.acc = sum[W-1:0];
      d.down = sum[W+1];
      d.up = ~sum[W+1] & sum[W];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign carry_up = q.up;
  assign carry_down = q.down;
  assign acc = q.acc;

endmodule
`default_nettype wire

// *** test/fracn_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module fracn_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched ports
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [23:0] wr_data,
  input wire logic ref_edge,
  input wire logic comparison_rate,
  input wire logic feedback_tick,
  input wire logic [19:0] active_ratio,
  input wire logic integer_mode,
  input wire logic prescaler_div2,
  input wire logic osc_wr_valid,
  input wire logic [3:0] osc_wr_addr,
  input wire logic [8:0] osc_wr_data,
  input wire logic [7:0] out_div_ratio,
  input wire logic out_div_enable
);
  logic fwd;
  assign fwd = wr_en && wr_addr == 5'h05;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  a_fwd_issue: assert property (fwd |=> osc_wr_valid)
    else $error("forward missing");
  a_fwd_cause: assert property (osc_wr_valid |-> $past(fwd))
    else $error("forward without write");
  a_fwd_word: assert property (fwd |=>
    {osc_wr_addr, osc_wr_data} == $past(wr_data[12:0]))
    else $error("forward word wrong");
  a_div_ratio: assert property (osc_wr_valid && osc_wr_addr == 4'h2
    |-> ##[0:1] out_div_ratio == 8'h01 << osc_wr_data[2:0])
    else $error("divider ratio wrong");
  a_div_enable: assert property (osc_wr_valid && osc_wr_addr == 4'h1
    |-> ##[0:1] out_div_enable == osc_wr_data[8])
    else $error("divider enable wrong");
  a_int_range: assert property (integer_mode |->
    active_ratio >= 20'h00010 && active_ratio <= 20'h7ffff)
    else $error("integer ratio out of range");
  a_apply_boundary: assert property (!feedback_tick |->
    $stable(active_ratio) && $stable(integer_mode))
    else $error("setting applied off boundary");
  a_cmp_cause: assert property (comparison_rate |-> $past(ref_edge))
    else $error("comparison pulse without edge");
  a_prescale_set: assert property (wr_en && wr_addr == 5'h08 |=>
    prescaler_div2 == $past(wr_data[19]))
    else $error("prescaler not updated");
  a_tick_gap: assert property (feedback_tick |=> !feedback_tick [*8])
    else $error("feedback ticks too close");
endmodule
bind fractional_n_divider_control fracn_props props_i (
  .clock(clock), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr),
  .wr_data(wr_data), .ref_edge(ref_edge),
  .comparison_rate(comparison_rate), .feedback_tick(feedback_tick),
  .active_ratio(active_ratio), .integer_mode(integer_mode),
  .prescaler_div2(prescaler_div2), .osc_wr_valid(osc_wr_valid),
  .osc_wr_addr(osc_wr_addr), .osc_wr_data(osc_wr_data),
  .out_div_ratio(out_div_ratio), .out_div_enable(out_div_enable));
`default_nettype wire

// *** test/fractional_n_divider_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module fractional_n_divider_control_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ref_edge = 1'b0;
  logic vco_edge = 1'b0;
  logic [4:0] rd_addr = 5'h00;
  logic wr_en, integer_mode, prescaler_div2, comparison_rate, feedback_tick;
  logic osc_wr_valid, out_div_enable;
  logic [4:0] wr_addr;
  logic [23:0] wr_data, rd_data, f;
  logic [19:0] active_ratio;
  logic [3:0] osc_wr_addr;
  logic [8:0] osc_wr_data;
  logic [7:0] out_div_ratio;
  logic [31:0] st = 32'h36b10c0d;
  logic [31:0] r, rv[2];
  int err_total = 0;
  int compares = 0;
  int vc = 0;
  int rc = 0;
  int qv[$], qr[$], rdv[3], nv[3];
  logic [4:0] ra[7] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h0c, 5'h10, 5'h1f};
  logic [23:0] re[7] = '{24'h000001, 24'h000010, 24'h000000, 24'h000082,
    24'h000000, 24'h080010, 24'h000000};
  always #12.5 clock = ~clock;
  function automatic logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  host_model host_model_i (.clock(clock), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data));
  fractional_n_divider_control fractional_n_divider_control_i (
    .clock(clock), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .ref_edge(ref_edge), .vco_edge(vco_edge),
    .comparison_rate(comparison_rate), .feedback_tick(feedback_tick),
    .active_ratio(active_ratio), .integer_mode(integer_mode),
    .prescaler_div2(prescaler_div2), .osc_wr_valid(osc_wr_valid),
    .osc_wr_addr(osc_wr_addr), .osc_wr_data(osc_wr_data),
    .out_div_ratio(out_div_ratio), .out_div_enable(out_div_enable));
  // Gappy edges, so intervals are counted in edges, not cycles
  always @(posedge clock) begin
    r = rnd();
    ref_edge <= r[0] | r[1];
    vco_edge <= r[2] | r[3];
    if (feedback_tick) begin
      qv.push_back(vc);
      vc = vco_edge;
    end else begin
      vc = vc + vco_edge;
    end
    if (comparison_rate) begin
      qr.push_back(rc);
      rc = ref_edge;
    end else begin
      rc = rc + ref_edge;
    end
  end
  task automatic complete_run();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [23:0] e,
    input logic [23:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [23:0] e);
    @(posedge clock);
    rd_addr <= a;
    @(posedge clock);
    #1 chk("rd_data", e, rd_data);
  endtask
  // First four intervals may straddle the change or the reload
  task automatic meas(input bit s, input int k, input int e);
    int n = 0;
    int sum = 0;
    if (s) qr.delete();
    else qv.delete();
    while ((s ? qr.size() : qv.size()) < k + 4) begin
      @(posedge clock);
      n++;
      if (n > 4000) begin
        err_total++;
        complete_run();
      end
    end
    for (int i = 4; i < k + 4; i++) sum += s ? qr[i] : qv[i];
    chk(s ? "ref_interval" : "vco_interval", e[23:0], sum[23:0]);
  endtask
  initial begin
    rv[0] = rnd();
    rv[1] = rnd();
    rdv = '{0, 1, 2 + rv[0] % 5};
    nv = '{15, 16, 17 + rv[1] % 40};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    #1 chk("active_ratio", 24'h000010, active_ratio);
    chk("out_div_ratio", 24'h000001, out_div_ratio);
    foreach (ra[i]) rd(ra[i], re[i]);
    foreach (rdv[i]) begin
      host_model_i.wr(5'h02, rdv[i][23:0]);
      meas(1'b1, 3, 3 * (rdv[i] == 0 ? 1 : rdv[i]));
    end
    host_model_i.int_mode();
    foreach (nv[i]) begin
      host_model_i.set_int(nv[i][18:0]);
      meas(1'b0, 3, 3 * (nv[i] < 16 ? 16 : nv[i]));
    end
    rd(5'h10, {5'h01, nv[2][18:0]});
    rd(5'h03, nv[2][23:0]);
    host_model_i.prescale(5000);
    #1 chk("prescaler_div2", 24'h000001, prescaler_div2);
    meas(1'b0, 3, 6 * nv[2]);
    host_model_i.prescale(3600);
    for (int s = 0; s < 4; s++) begin
      host_model_i.frac_mode(s[1:0]);
      host_model_i.set_frac(20, 24'h400000);
      meas(1'b0, 8, 162);
    end
    chk("integer_mode", 24'h000000, integer_mode);
    rd(5'h04, 24'h400000);
    f = host_model_i.frac_ceil(1, 10);
    host_model_i.exact(10);
    host_model_i.set_frac(20, f);
    meas(1'b0, 10, 201);
    host_model_i.exact(0);
    for (int k = 0; k < 8; k++) begin
      host_model_i.out_div(k[2:0]);
      repeat (2) @(posedge clock);
      #1 chk("out_div_ratio", 24'h000001 << k, out_div_ratio);
    end
    chk("out_div_enable", 24'h000001, out_div_enable);
    host_model_i.osc(4'h1, 9'h000);
    #1 chk("osc_wr_word", {10'h000, 1'b1, 4'h1, 9'h000},
      {10'h000, osc_wr_valid, osc_wr_addr, osc_wr_data});
    repeat (2) @(posedge clock);
    #1 chk("out_div_enable", 24'h000000, out_div_enable);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1 chk("out_div_ratio", 24'h000001, out_div_ratio);
    chk("active_ratio", 24'h000010, active_ratio);
    complete_run();
  end
endmodule
`default_nettype wire

// *** test/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clock,
  // Register writes
  output logic wr_en,
  output logic [4:0] wr_addr,
  output logic [23:0] wr_data
);
  initial begin
    wr_en = 1'b0;
    wr_addr = 5'h00;
    wr_data = 24'h000000;
  end
  // Released lines flip so stale values never look valid
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask
  task automatic int_mode();
    wr(5'h06, 24'h000082);
  endtask
  task automatic frac_mode(input logic [1:0] s);
    wr(5'h06, {22'h000200, s});
  endtask
  task automatic set_int(input logic [18:0] n);
    wr(5'h03, {5'h00, n});
  endtask
  task automatic set_frac(input int n, input logic [23:0] f);
    if (n < 20) n = 20;
    if (n > 524284) n = 524284;
    wr(5'h03, n[23:0]);
    wr(5'h04, f);
  endtask
  task automatic prescale(input int mhz);
    wr(5'h08, {4'h0, mhz >= 4000, 19'h00000});
  endtask
  task automatic osc(input logic [3:0] a, input logic [8:0] d);
    wr(5'h05, {11'h000, a, d});
  endtask
  // Select first, so the divider never runs at a stale ratio
  task automatic out_div(input logic [2:0] k);
    osc(4'h2, {6'h00, k});
    osc(4'h1, 9'h100);
  endtask
  // One common step plan may be kept for all channels
  task automatic exact(input int steps);
    if (steps < 16384) wr(5'h0c, steps[23:0]);
  endtask
  function automatic logic [23:0] frac_ceil(input int p, input int q);
    frac_ceil = 24'(((longint'(p) << 24) + q - 1) / q);
  endfunction
endmodule
`default_nettype wire
